// >>> core/adc_cmd_map.vh
// Constants for the serial command decoder: opcodes, register file layout, timing.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef ADC_CMD_MAP_VH
`define ADC_CMD_MAP_VH
`define OPC_EXIT_LP      7'h00
`define OPC_ENTER_LP     7'h01
`define OPC_RESTART      7'h02
`define OPC_SOFT_RESET   7'h03
`define OPC_READ_ONCE    7'h09
`define OPC_READ_CONT    7'h0a
`define OPC_STOP_CONT    7'h0b
`define OPC_NOP          8'hff
`define OPC_REG_READ     4'h2
`define OPC_REG_WRITE    4'h4
`define OPC_EXT_OFS_CAL  8'h60
`define OPC_EXT_GAIN_CAL 8'h61
`define OPC_INT_OFS_CAL  8'h62
`define NUM_REGS         16
`define REG_OFC0         4'h4
`define REG_FSC0         4'h7
`define REG_MUX1         4'h2
`define REG_IDAC0        4'h0a
`define VREF_LSB         5
`define OUT_SEL_BIT      3
`define REG_RESET_VALUE  8'h00
`define RESET_HOLD_NS    600000
`define CLOCK_PERIOD_NS  10
`define RESET_HOLD_CYC   (`RESET_HOLD_NS / `CLOCK_PERIOD_NS)
`endif

// >>> core/cmd_shift_unit.v
// Serial byte framer: samples link clock, data-in and select, shifts MSB first.
// Assumes link inputs are asynchronous to i_clock; edges found by sampling.
`timescale 1ns/1ps
module cmd_shift_unit (
  input  wire       i_clock,    // Core clock
  input  wire       i_rst_n,    // Synchronised reset, active low
  input  wire       i_sclk,     // Link clock pin
  input  wire       i_cs_n,     // Chip select pin, active low
  input  wire       i_din,      // Data-in pin
  input  wire [7:0] i_tx_byte,  // Byte to send next
  output reg        o_rise,     // Link clock rising edge pulse
  output reg        o_fall,     // Link clock falling edge pulse
  output reg        o_sel,      // Chip select asserted, filtered
  output reg        o_byte_done,// Eighth rising edge pulse
  output reg  [7:0] o_rx_byte,  // Received byte
  output reg        o_load,     // Request for next transmit byte
  output reg        o_dout      // Serial data bit
);
  reg [2:0] sclk_sync_reg;
  reg [2:0] cs_sync_reg;
  reg [2:0] din_sync_reg;
  reg       sclk_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] rx_sh_reg;
  reg [7:0] tx_sh_reg;

  // Three-stage sampling; a level counts once stages two and three agree
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg   <= 3'h7;
      din_sync_reg  <= 3'h0;
      sclk_reg      <= 1'b0;
      o_sel         <= 1'b0;
      o_rise        <= 1'b0;
      o_fall        <= 1'b0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], i_sclk};
      cs_sync_reg   <= {cs_sync_reg[1:0], i_cs_n};
      din_sync_reg  <= {din_sync_reg[1:0], i_din};
      o_rise        <= 1'b0;
      o_fall        <= 1'b0;
      if (sclk_sync_reg[1] == sclk_sync_reg[2] && sclk_sync_reg[2] != sclk_reg) begin
        sclk_reg <= sclk_sync_reg[2];
        o_rise   <= sclk_sync_reg[2] & o_sel;
        o_fall   <= ~sclk_sync_reg[2] & o_sel;
      end
      if (cs_sync_reg[1] == cs_sync_reg[2])
        o_sel <= ~cs_sync_reg[2];
    end
  end

  // Byte framing; deselect resynchronises the framer
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_cnt_reg <= 3'h0;
      rx_sh_reg   <= 8'h00;
      tx_sh_reg   <= 8'h00;
      o_rx_byte   <= 8'h00;
      o_byte_done <= 1'b0;
      o_load      <= 1'b0;
      o_dout      <= 1'b0;
    end else begin
      o_byte_done <= 1'b0;
      o_load      <= 1'b0;
      if (!o_sel) begin
        bit_cnt_reg <= 3'h0;
        tx_sh_reg   <= i_tx_byte;
        o_dout      <= i_tx_byte[7];
      end else if (o_rise) begin
        rx_sh_reg   <= {rx_sh_reg[6:0], din_sync_reg[2]};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
          o_rx_byte   <= {rx_sh_reg[6:0], din_sync_reg[2]};
          o_byte_done <= 1'b1;
          o_load      <= 1'b1;
        end
      end else if (o_fall) begin
        if (bit_cnt_reg == 3'h0) begin
          tx_sh_reg <= i_tx_byte;
          o_dout    <= i_tx_byte[7];
        end else begin
          tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
          o_dout    <= tx_sh_reg[6];
        end
      end
    end
  end
endmodule

// >>> core/adc_serial_command_decoder.v
// Serial command decoder of a delta-sigma converter: commands, register file, result readout.
// Assumes link pins are asynchronous; converter core signals share i_clock.
// Function
// - Exit low power at eighth rising edge
// - Enter low power after current conversion
// - Low power leaves reference per its field
// - Two-byte restart clears filter, new conversion
// - Soft reset restores registers, clears filter
// - Soft reset leaves serial framer untouched
// - Soft reset holds reset for 0.6ms
// - Continuous mode auto-loads each result, except during register readout
// - Continuous mode applies at next ready
// - Stop command ends loading after next ready, whose result still loads
// - Single read copies latest result
// - Single read accepted during last byte
// - Block read n+1 registers, wrapping address
// - Commands during register readout are ignored
// - Block write stores n+1 consecutive bytes
// - External offset calibration updates offset coefficient
// - External gain calibration updates fullscale coefficient
// - Internal offset calibration shorts inputs, updates offset
// - Power-up in continuous read mode
// - Config bit puts ready on output pin while deselected
`timescale 1ns/1ps
`include "adc_cmd_map.vh"
module adc_serial_command_decoder #(
  parameter RESET_HOLD = `RESET_HOLD_CYC            // Soft reset hold in core cycles
) (
  input  wire        i_clock,          // Core clock, 100 MHz
  input  wire        i_rstn,           // Reset, active low, asynchronous
  input  wire        i_sclk,           // Link clock pin
  input  wire        i_cs_n,           // Chip select pin, active low
  input  wire        i_din,            // Data-in pin
  input  wire        i_conv_done,      // Converter finished a result, pulse
  input  wire [23:0] i_conv_result,    // Converter result word
  input  wire        i_cal_done,       // Calibration finished, pulse
  input  wire [23:0] i_cal_value,      // Calibration coefficient
  output reg         o_shared_output_pin, // Data-out pin
  output reg         o_result_ready_n, // Data ready, active low
  output reg         o_low_power,      // Power-saving state
  output reg         o_ref_on,         // Reference powered
  output reg         o_filter_clear,   // Filter clear and restart, pulse
  output reg         o_core_reset,     // Registers and filter held in reset
  output reg  [1:0]  o_cal_start,      // Calibration kind, valid with strobe
  output reg         o_cal_strobe,     // Calibration start, pulse
  output reg         o_input_short     // Inputs shorted internally
);
  localparam ST_CMD   = 3'd0;
  localparam ST_COUNT = 3'd1;
  localparam ST_RDREG = 3'd2;
  localparam ST_WRREG = 3'd3;
  localparam ST_SYNC2 = 3'd4;
  localparam ST_SKIP  = 3'd5;

  reg  [1:0]  rst_sync_reg;
  wire        rst_n = rst_sync_reg[1];
  wire        rise;
  wire        fall;
  wire        sel;
  wire        byte_done;
  wire [7:0]  rx_byte;
  wire        load;
  wire        dout;
  reg  [7:0]  regs [0:`NUM_REGS-1];
  reg  [2:0]  state_reg;
  reg  [3:0]  addr_reg;
  reg  [3:0]  left_reg;
  reg         is_read_reg;
  reg         cont_reg;
  reg         cont_pend_reg;
  reg         cont_next_reg;
  reg         sleep_pend_reg;
  reg  [23:0] out_sh_reg;
  reg  [1:0]  out_idx_reg;
  reg  [7:0]  tx_byte_reg;
  reg  [23:0] latest_reg;
  reg  [1:0]  cal_kind_reg;
  reg         cal_busy_reg;
  reg  [19:0] hold_cnt_reg;
  integer     k;

  // Reset release through two flip-flops
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  cmd_shift_unit u_shift (
    .i_clock     (i_clock),
    .i_rst_n     (rst_n),
    .i_sclk      (i_sclk),
    .i_cs_n      (i_cs_n),
    .i_din       (i_din),
    .i_tx_byte   (tx_byte_reg),
    .o_rise      (rise),
    .o_fall      (fall),
    .o_sel       (sel),
    .o_byte_done (byte_done),
    .o_rx_byte   (rx_byte),
    .o_load      (load),
    .o_dout      (dout)
  );

  // Next address with wrap past the last register
  function [3:0] next_addr;
    input [3:0] a;
    begin
      next_addr = a + 4'h1;
    end
  endfunction

  // Result byte after the given one, wrapping after the third
  function [1:0] next_idx;
    input [1:0] i;
    begin
      next_idx = (i == 2'd2) ? 2'd0 : i + 2'd1;
    end
  endfunction

  // One byte of a result word, most significant first
  function [7:0] result_byte;
    input [23:0] w;
    input [1:0]  i;
    begin
      result_byte = (i == 2'd0) ? w[23:16] : (i == 2'd1) ? w[15:8] : w[7:0];
    end
  endfunction

  // Output pin; optional ready indication while deselected
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n)
      o_shared_output_pin <= 1'b0;
    else if (regs[`REG_IDAC0][`OUT_SEL_BIT] && !sel)
      o_shared_output_pin <= o_result_ready_n;
    else
      o_shared_output_pin <= dout;
  end

  // Reference follows its own field, independent of low power
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n)
      o_ref_on <= 1'b0;
    else
      o_ref_on <= regs[`REG_MUX1][`VREF_LSB+1:`VREF_LSB] != 2'b00;
  end

  // Command decoder, register file, result path
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      for (k = 0; k < `NUM_REGS; k = k + 1)
        regs[k] <= `REG_RESET_VALUE;
      state_reg        <= ST_CMD;
      addr_reg         <= 4'h0;
      left_reg         <= 4'h0;
      is_read_reg      <= 1'b0;
      cont_reg         <= 1'b1;
      cont_pend_reg    <= 1'b0;
      cont_next_reg    <= 1'b1;
      sleep_pend_reg   <= 1'b0;
      out_sh_reg       <= 24'h00_0000;
      out_idx_reg      <= 2'd0;
      tx_byte_reg      <= 8'h00;
      latest_reg       <= 24'h00_0000;
      cal_kind_reg     <= 2'd0;
      cal_busy_reg     <= 1'b0;
      hold_cnt_reg     <= 20'h0_0000;
      o_result_ready_n <= 1'b1;
      o_low_power      <= 1'b0;
      o_filter_clear   <= 1'b0;
      o_core_reset     <= 1'b0;
      o_cal_start      <= 2'd0;
      o_cal_strobe     <= 1'b0;
      o_input_short    <= 1'b0;
    end else begin
      o_filter_clear <= 1'b0;
      o_cal_strobe   <= 1'b0;
      // Soft reset hold keeps registers and filter cleared
      if (hold_cnt_reg != 20'h0_0000) begin
        hold_cnt_reg <= hold_cnt_reg - 20'h0_0001;
        o_core_reset <= 1'b1;
        for (k = 0; k < `NUM_REGS; k = k + 1)
          regs[k] <= `REG_RESET_VALUE;
        cont_reg      <= 1'b1;
        cont_next_reg <= 1'b1;
        cont_pend_reg <= 1'b0;
      end else begin
        o_core_reset <= 1'b0;
      end
      // New result: ready falls, mode change applies, auto-load
      if (i_conv_done && !o_core_reset) begin
        latest_reg       <= i_conv_result;
        o_result_ready_n <= 1'b0;
        if (cont_pend_reg) begin
          cont_reg      <= cont_next_reg;
          cont_pend_reg <= 1'b0;
        end
        if (cont_reg && state_reg != ST_RDREG) begin
          out_sh_reg  <= i_conv_result;
          out_idx_reg <= 2'd0;
        end
        if (sleep_pend_reg) begin
          o_low_power    <= 1'b1;
          sleep_pend_reg <= 1'b0;
        end
      end else if (fall && sel) begin
        o_result_ready_n <= 1'b1;
      end
      // Calibration completion updates the coefficient registers
      if (i_cal_done && cal_busy_reg) begin
        cal_busy_reg  <= 1'b0;
        o_input_short <= 1'b0;
        if (cal_kind_reg == 2'd1) begin
          {regs[`REG_FSC0+2], regs[`REG_FSC0+1], regs[`REG_FSC0]} <= i_cal_value;
        end else begin
          {regs[`REG_OFC0+2], regs[`REG_OFC0+1], regs[`REG_OFC0]} <= i_cal_value;
        end
      end
      // Next transmit byte
      if (load || !sel) begin
        if (state_reg == ST_RDREG) begin
          tx_byte_reg <= regs[addr_reg];
        end else if (load) begin
          // Step to the following byte, back to the first after the third
          tx_byte_reg <= result_byte(out_sh_reg, next_idx(out_idx_reg));
          out_idx_reg <= next_idx(out_idx_reg);
        end else begin
          tx_byte_reg <= result_byte(out_sh_reg, out_idx_reg);
        end
      end
      if (!sel && state_reg != ST_CMD) begin
        state_reg <= ST_CMD;
      end else if (byte_done) begin
        case (state_reg)
          ST_CMD: begin
            if (rx_byte[7:1] == `OPC_EXIT_LP) begin
              o_low_power    <= 1'b0;
              sleep_pend_reg <= 1'b0;
            end else if (rx_byte[7:1] == `OPC_ENTER_LP) begin
              sleep_pend_reg <= 1'b1;
            end else if (rx_byte[7:1] == `OPC_RESTART) begin
              state_reg <= ST_SYNC2;
            end else if (rx_byte[7:1] == `OPC_SOFT_RESET) begin
              hold_cnt_reg <= RESET_HOLD[19:0];
            end else if (rx_byte[7:1] == `OPC_READ_ONCE) begin
              out_sh_reg  <= latest_reg;
              tx_byte_reg <= result_byte(latest_reg, 2'd0);
              out_idx_reg <= 2'd0;
            end else if (rx_byte[7:1] == `OPC_READ_CONT) begin
              cont_pend_reg <= 1'b1;
              cont_next_reg <= 1'b1;
            end else if (rx_byte[7:1] == `OPC_STOP_CONT) begin
              cont_pend_reg <= 1'b1;
              cont_next_reg <= 1'b0;
            end else if (rx_byte[7:4] == `OPC_REG_READ || rx_byte[7:4] == `OPC_REG_WRITE) begin
              addr_reg    <= rx_byte[3:0];
              is_read_reg <= rx_byte[7:4] == `OPC_REG_READ;
              state_reg   <= ST_COUNT;
            end else if (rx_byte == `OPC_EXT_OFS_CAL || rx_byte == `OPC_EXT_GAIN_CAL ||
                         rx_byte == `OPC_INT_OFS_CAL) begin
              cal_kind_reg  <= rx_byte[1:0];
              o_cal_start   <= rx_byte[1:0];
              o_cal_strobe  <= 1'b1;
              cal_busy_reg  <= 1'b1;
              o_input_short <= rx_byte == `OPC_INT_OFS_CAL;
            end
            // Other bytes, the no-operation byte among them, fall through
          end
          ST_SYNC2: begin
            if (rx_byte[7:1] == `OPC_RESTART)
              o_filter_clear <= 1'b1;
            state_reg <= ST_CMD;
          end
          ST_COUNT: begin
            left_reg  <= rx_byte[3:0];
            state_reg <= is_read_reg ? ST_RDREG : ST_WRREG;
            if (is_read_reg)
              tx_byte_reg <= regs[addr_reg];
          end
          ST_RDREG: begin
            // Incoming bytes are ignored while registers shift out
            addr_reg <= next_addr(addr_reg);
            tx_byte_reg <= regs[next_addr(addr_reg)];
            left_reg <= left_reg - 4'h1;
            if (left_reg == 4'h0)
              state_reg <= ST_CMD;
          end
          ST_WRREG: begin
            regs[addr_reg] <= rx_byte;
            addr_reg <= next_addr(addr_reg);
            left_reg <= left_reg - 4'h1;
            if (left_reg == 4'h0)
              state_reg <= ST_CMD;
          end
          default: begin
            state_reg <= ST_CMD;
          end
        endcase
      end
    end
  end
endmodule

// >>> test/decoder_checker_properties.sv
// Checker for the serial command decoder outputs.
// Assumes it is bound to the decoder top module ports.
`timescale 1ns/1ps
module decoder_checker #(
  parameter RESET_HOLD = 50 // Soft reset hold cycles
) (
  input wire       i_clock,          // Core clock
  input wire       i_rstn,           // Reset, active low
  input wire       i_cs_n,           // Chip select
  input wire       i_conv_done,      // Result pulse
  input wire       i_cal_done,       // Calibration end
  input wire       o_result_ready_n, // Ready, active low
  input wire       o_low_power,      // Sleep state
  input wire       o_ref_on,         // Reference power
  input wire       o_filter_clear,   // Restart pulse
  input wire       o_core_reset,     // Reset hold
  input wire [1:0] o_cal_start,      // Calibration kind
  input wire       o_cal_strobe,     // Calibration start
  input wire       o_input_short     // Inputs shorted
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  reg [31:0] hold_reg;
  // Length of the current hold
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) hold_reg <= 32'h0000_0000;
    else hold_reg <= o_core_reset ? hold_reg + 1 : 32'h0000_0000;
  end
  property p_exit; $fell(o_low_power) |-> !i_cs_n; endproperty
  a_exit: assert property (p_exit) else $error("wake without select");
  property p_enter;
    $rose(o_low_power) |-> $past(i_conv_done, 1) || $past(i_conv_done, 2) || $past(i_conv_done, 3);
  endproperty
  a_enter: assert property (p_enter) else $error("sleep before conversion end");
  property p_ref; $rose(o_low_power) |-> $stable(o_ref_on); endproperty
  a_ref: assert property (p_ref) else $error("reference moved on sleep");
  property p_clear; o_filter_clear |=> !o_filter_clear; endproperty
  a_clear: assert property (p_clear) else $error("restart pulse too long");
  property p_hold; $fell(o_core_reset) |-> hold_reg inside {[RESET_HOLD:RESET_HOLD+1]}; endproperty
  a_hold: assert property (p_hold) else $error("reset hold length wrong");
  property p_kind; o_cal_strobe |-> o_cal_start != 2'h3 ##1 !o_cal_strobe; endproperty
  a_kind: assert property (p_kind) else $error("bad calibration strobe");
  property p_short; o_cal_strobe && o_cal_start == 2'h2 |-> ##[0:3] o_input_short; endproperty
  a_short: assert property (p_short) else $error("inputs not shorted");
  property p_unshort;
    $fell(o_input_short) |-> $past(i_cal_done, 1) || $past(i_cal_done, 2) || $past(i_cal_done, 3);
  endproperty
  a_unshort: assert property (p_unshort) else $error("short ended early");
  property p_ready; i_conv_done && !o_core_reset |-> ##[1:3] !o_result_ready_n; endproperty
  a_ready: assert property (p_ready) else $error("ready did not fall");
  c_sleep: cover property ($rose(o_low_power));
  c_hold: cover property ($fell(o_core_reset));
  c_short: cover property ($rose(o_input_short));
endmodule
bind adc_serial_command_decoder decoder_checker #(.RESET_HOLD(RESET_HOLD)) checker_i (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_cs_n(i_cs_n), .i_conv_done(i_conv_done),
  .i_cal_done(i_cal_done), .o_result_ready_n(o_result_ready_n), .o_low_power(o_low_power),
  .o_ref_on(o_ref_on), .o_filter_clear(o_filter_clear), .o_core_reset(o_core_reset),
  .o_cal_start(o_cal_start), .o_cal_strobe(o_cal_strobe), .o_input_short(o_input_short));

// >>> test/host_model.sv
// Host controller model: frames bytes on the link, MSB first.
// Assumes the device changes data-out after link clock falls.
`timescale 1ns/1ps
module host_model (
  output reg  o_sclk, // Link clock
  output reg  o_cs_n, // Chip select, active low
  output reg  o_din,  // Data to device
  input  wire i_dout  // Data from device
);
  // Idle link at time zero
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din  = 1'b1;
  end
  // Opens a frame; clock stands low
  task sel;
    begin
      o_cs_n = 1'b0;
      #150;
    end
  endtask
  // Closes a frame; released data line toggles
  task desel;
    begin
      #150;
      o_cs_n = 1'b1;
      o_din  = ~o_din;
      #300;
    end
  endtask
  // One byte each way, MSB first, sampled before the fall
  task xfer(input [7:0] tx, output [7:0] rx);
    integer b;
    begin
      for (b = 7; b >= 0; b = b - 1) begin
        o_din = tx[b];
        #62.5;
        o_sclk = 1'b1;
        #62.5;
        rx[b]  = i_dout;
        o_sclk = 1'b0;
      end
    end
  endtask
endmodule

// >>> test/tb.sv
// Self-checking bench for the serial command decoder.
// Assumes host_model drives the link; converter is modelled here.
`timescale 1ns/1ps
module tb;
  localparam HOLD = 50;
  reg         i_clock, i_rstn, i_conv_done, i_cal_done;
  reg  [23:0] i_conv_result, i_cal_value, word, got, held;
  wire        sclk, cs_n, din, dout, ready_n, low_power, ref_on;
  wire        filter_clear, core_reset, cal_strobe, input_short;
  wire [1:0]  cal_start;
  integer     failures, check_count, seed, clears, cals, k;
  reg  [1:0]  last_kind;
  reg  [7:0]  rx;
  reg  [7:0]  wdat [0:4];
  adc_serial_command_decoder #(.RESET_HOLD(HOLD)) adc_serial_command_decoder_i (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
    .i_conv_done(i_conv_done), .i_conv_result(i_conv_result), .i_cal_done(i_cal_done),
    .i_cal_value(i_cal_value), .o_shared_output_pin(dout), .o_result_ready_n(ready_n),
    .o_low_power(low_power), .o_ref_on(ref_on), .o_filter_clear(filter_clear),
    .o_core_reset(core_reset), .o_cal_start(cal_start), .o_cal_strobe(cal_strobe),
    .o_input_short(input_short));
  host_model host_model_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout));
  // Core clock
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // Tallies decoder strobes
  always @(posedge i_clock) begin
    if (filter_clear === 1'b1) clears = clears + 1;
    if (cal_strobe === 1'b1) begin
      cals = cals + 1;
      last_kind = cal_start;
    end
  end
  function ref_exp(input [7:0] r);
    ref_exp = |r[6:5];
  endfunction
  task chk(input [23:0] g, input [23:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task give_verdict;
    begin
      if (failures == 0 && check_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task conv(input [23:0] v);
    begin
      @(negedge i_clock);
      i_conv_result = v;
      i_conv_done = 1'b1;
      @(negedge i_clock);
      i_conv_done = 1'b0;
      repeat (5) @(negedge i_clock);
    end
  endtask
  task cmd(input [7:0] op);
    begin
      host_model_i.sel;
      host_model_i.xfer(op, rx);
      host_model_i.desel;
      @(negedge i_clock);
    end
  endtask
  task rd24(input [7:0] last, output [23:0] w);
    begin
      host_model_i.xfer(8'hff, w[23:16]);
      host_model_i.xfer(8'hff, w[15:8]);
      host_model_i.xfer(last, w[7:0]);
    end
  endtask
  task register_block_write_cmd(input [3:0] a, input [3:0] n);
    integer j;
    begin
      host_model_i.sel;
      host_model_i.xfer({4'h4, a}, rx);
      host_model_i.xfer({4'h0, n}, rx);
      for (j = 0; j <= n; j = j + 1) host_model_i.xfer(wdat[j], rx);
      host_model_i.desel;
    end
  endtask
  task register_block_read_cmd(input [3:0] a, input [3:0] n, input [7:0] fill);
    integer j;
    begin
      host_model_i.sel;
      host_model_i.xfer({4'h2, a}, rx);
      host_model_i.xfer({4'h0, n}, rx);
      for (j = 0; j <= n; j = j + 1) begin
        host_model_i.xfer(fill, rx);
        chk(rx, wdat[j]);
      end
      host_model_i.desel;
      @(negedge i_clock);
    end
  endtask
  // Cuts a hang short
  initial begin
    #500000;
    failures = failures + 1;
    give_verdict;
  end
  // Main sequence
  initial begin
    seed = 4; failures = 0; check_count = 0; clears = 0; cals = 0;
    i_rstn = 1'b0; i_conv_done = 1'b0; i_cal_done = 1'b0;
    i_conv_result = 24'h00_0000; i_cal_value = 24'h00_0000;
    repeat (2) @(negedge i_clock);
    i_rstn = 1'b1;
    repeat (10) @(negedge i_clock);
    chk(ready_n, 1'b1);
    for (k = 0; k < 4; k = k + 1) begin
      word = $random(seed);
      conv(word);
      chk(ready_n, 1'b0);
      host_model_i.sel;
      rd24({7'h09, k[1]}, got);
      chk(got, word);
      if (k[0]) begin
        rd24(8'hff, got);
        chk(got, word);
      end
      host_model_i.desel;
    end
    for (k = 0; k < 2; k = k + 1) begin
      cmd({7'h01, k[0]});
      chk(low_power, 1'b0);
      word = $random(seed);
      conv(word);
      chk(low_power, 1'b1);
      cmd({7'h00, k[0]});
      chk(low_power, 1'b0);
    end
    clears = 0;
    host_model_i.sel;
    host_model_i.xfer(8'h04, rx);
    host_model_i.xfer(8'h05, rx);
    host_model_i.desel;
    chk(clears[23:0], 24'h00_0001);
    for (k = 0; k < 5; k = k + 1) begin
      word = $random(seed);
      wdat[k] = word[7:0];
    end
    register_block_write_cmd(4'he, 4'h4);
    chk(ref_on, ref_exp(wdat[4]));
    cals = 0;
    register_block_read_cmd(4'he, 4'h4, 8'h60);
    cmd(8'h30);
    chk(cals[23:0], 24'h00_0000);
    for (k = 0; k < 3; k = k + 1) begin
      cmd({6'h18, k[1:0]});
      chk(cals[23:0], k + 1);
      chk(last_kind, k[1:0]);
      chk(input_short, k == 2);
      word = $random(seed);
      i_cal_value = word;
      i_cal_done = 1'b1;
      @(negedge i_clock);
      i_cal_done = 1'b0;
      repeat (4) @(negedge i_clock);
      chk(input_short, 1'b0);
      wdat[0] = word[7:0];
      wdat[1] = word[15:8];
      wdat[2] = word[23:16];
      register_block_read_cmd((k == 1) ? 4'h7 : 4'h4, 4'h2, 8'hff);
    end
    cmd(8'h16);
    for (k = 0; k < 2; k = k + 1) begin
      held = word;
      word = $random(seed);
      conv(word);
    end
    host_model_i.sel;
    rd24(8'hff, got);
    chk(got, held);
    host_model_i.xfer(8'h13, rx);
    rd24(8'hff, got);
    host_model_i.desel;
    chk(got, word);
    for (k = 0; k < 3; k = k + 1) begin
      word = $random(seed);
      conv(word);
      if (k == 0) cmd(8'h15);
    end
    host_model_i.sel;
    rd24(8'hff, got);
    host_model_i.desel;
    chk(got, word);
    wdat[0] = 8'h08;
    register_block_write_cmd(4'ha, 4'h0);
    conv(word | 24'h80_0000);
    chk(dout, 1'b0);
    for (k = 0; k < 2; k = k + 1) begin
      host_model_i.sel;
      host_model_i.xfer({7'h03, k[0]}, rx);
      repeat (20) @(negedge i_clock);
      chk(core_reset, 1'b1);
      host_model_i.desel;
      repeat (HOLD) @(negedge i_clock);
      chk(core_reset, 1'b0);
      wdat[0] = 8'h00; wdat[1] = 8'h00; wdat[2] = 8'h00; wdat[3] = 8'h00; wdat[4] = 8'h00;
      register_block_read_cmd(4'he, 4'h4, 8'hff);
      chk(ref_on, 1'b0);
    end
    give_verdict;
  end
endmodule
